// [egress_arb_defs.svh]
// named constants for the egress priority arbiter
// assumes one switch clock; included by bare name
`ifndef EGRESS_ARB_DEFS_SVH
`define EGRESS_ARB_DEFS_SVH

`define N_UC          8
`define N_SRC         9
`define N_PRIO        4
`define MC_IDX        4'h8
`define UC_WRAP       4'h8
`define PTR_RST       4'h0
`define CNT_RST       4'h0
`define QUEUE_DEPTH   4'h8
`define OCC_RST       4'h0
`define OCC_ONE       4'h1
`define PRIO_TOP      2'h3
`define PRIO_RST      2'h0
`define THR2_RST      4'h1
`define THR1_RST      4'h2
`define THR0_RST      4'h3

`endif

// [egress_arb_pkg.sv]
// types shared by the egress priority arbiter files
// assumes egress_arb_defs.svh for the numeric constants
package egress_arb_pkg;

  // head-of-line packet offered by one source
  typedef struct packed {
    logic       valid;
    logic [1:0] prio;
  } head_t;

  // per-priority weighting configuration
  typedef struct packed {
    logic       weighted_mode_enable;
    logic       favour_unicast_select;
    logic [3:0] preferred_packet_count;
  } wrr_cfg_t;

  // free-buffer thresholds for priorities 0..2
  typedef struct packed {
    logic [3:0] lowest_prio_threshold;
    logic [3:0] low_prio_threshold;
    logic [3:0] high_prio_threshold;
  } thresholds_t;

  typedef enum logic {
    CLASS_MULTICAST,
    CLASS_UNICAST
  } traffic_class_t;

endpackage

// [weighted_round_robin.sv]
// one weighted round-robin arbiter for a single priority level
// assumes heads are stable until take is pulsed for the chosen source
`timescale 1ns/1ns
`default_nettype none
`include "egress_arb_defs.svh"

module weighted_round_robin
  import egress_arb_pkg::*;
(
  input  wire logic                clk,
  input  wire logic                nrst,
  input  wire logic                ce,
  input  wire logic [`N_UC-1:0]    uc_req,
  input  wire logic                mc_req,
  input  wire wrr_cfg_t            cfg,
  input  wire logic                take,
  output logic                     cand_valid,
  output logic [3:0]               cand_idx
);

  logic [3:0] ptr_q;
  logic [3:0] ptr_d;
  logic [3:0] cnt_q;
  logic [3:0] cnt_d;
  logic [3:0] uc_idx;
  logic [3:0] all_idx;
  logic       any_uc;
  logic       pref_avail;
  logic       nonp_avail;
  logic       nonp_slot;
  logic       pick_pref;
  logic       pick_uc;

  // first requester at or after ptr, wrapping at 8 or 9 sources
  function automatic logic [3:0] rr_pick(input logic [`N_SRC-1:0] req,
                                         input logic [3:0] ptr,
                                         input logic wrap9);
    logic [4:0] s;
    logic       found;
    rr_pick = ptr;
    found = 1'b0;
    for (int i = 0; i < `N_SRC; i++)
    begin
      s = {1'b0, ptr} + 5'(i);
      if (wrap9 && s >= 5'(`N_SRC))
        s = s - 5'(`N_SRC);
      else if (!wrap9 && s >= 5'(`N_UC))
        s = s - 5'(`N_UC);
      if (!found && req[s[3:0]])
      begin
        found = 1'b1;
        rr_pick = s[3:0];
      end
    end
  endfunction

  always_comb
  begin
    any_uc     = |uc_req;
    uc_idx     = rr_pick({1'b0, uc_req}, ptr_q, 1'b0);
    all_idx    = rr_pick({mc_req, uc_req}, ptr_q, 1'b1);
    pref_avail = cfg.favour_unicast_select ? any_uc : mc_req;
    nonp_avail = cfg.favour_unicast_select ? mc_req : any_uc;
    // count reached: slot owed to the other class
    nonp_slot  = cnt_q >= cfg.preferred_packet_count;
    pick_pref  = nonp_slot ? !nonp_avail : pref_avail;
    pick_uc    = pick_pref == cfg.favour_unicast_select;
    cand_valid = any_uc | mc_req;
    ptr_d      = ptr_q;
    cnt_d      = cnt_q;
    if (!cfg.weighted_mode_enable)
    begin
      cand_idx = all_idx;
      if (take)
        ptr_d = (all_idx == `MC_IDX) ? `PTR_RST : all_idx + 4'h1;
    end
    else
    begin
      cand_idx = pick_uc ? uc_idx : `MC_IDX;
      if (take)
      begin
        if (pick_uc)
          ptr_d = (uc_idx + 4'h1 == `UC_WRAP) ? `PTR_RST : uc_idx + 4'h1;
        if (pick_pref && !nonp_slot)
          cnt_d = cnt_q + 4'h1;
        else if (!pick_pref && nonp_slot)
          cnt_d = `CNT_RST;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      ptr_q <= `PTR_RST;
      cnt_q <= `CNT_RST;
    end
    else if (ce)
    begin
      ptr_q <= ptr_d;
      cnt_q <= cnt_d;
    end
  end

endmodule
`default_nettype wire

// [egress_priority_wrr_arbiter.sv]
// egress port arbiter: four weighted round-robin stages under strict priority,
// eight-packet output queue occupancy with per-priority watermark flow control
// assumes sources hold their head packet until granted and pop on grant_valid
`timescale 1ns/1ns
`default_nettype none
`include "egress_arb_defs.svh"

module egress_priority_wrr_arbiter
  import egress_arb_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  nrst,
  input  wire logic                  ce,
  input  wire head_t [`N_SRC-1:0]    heads,
  input  wire logic [`N_UC-1:0]      ingress_full,
  input  wire wrr_cfg_t [`N_PRIO-1:0] wrr_cfg,
  input  wire logic                  thr_load,
  input  wire thresholds_t           thr_in,
  input  wire logic                  egress_retire,
  output logic [`N_SRC-1:0]          grant,
  output logic                       grant_valid,
  output logic [1:0]                 grant_prio,
  output logic [`N_PRIO-1:0]         prio_stall,
  output logic                       queue_full,
  output logic [3:0]                 free_buffers,
  output logic [`N_UC-1:0]           link_retry,
  output thresholds_t                thresholds
);

  logic [3:0]              occ_q;
  logic [3:0]              occ_d;
  thresholds_t             thr_q;
  thresholds_t             thr_d;
  logic [`N_SRC-1:0]       grant_q;
  logic [`N_SRC-1:0]       grant_d;
  logic                    gvalid_q;
  logic                    gvalid_d;
  logic [1:0]              gprio_q;
  logic [1:0]              gprio_d;
  logic [`N_PRIO-1:0]      stall_q;
  logic [`N_PRIO-1:0]      stall_d;
  logic                    full_q;
  logic                    full_d;
  logic [3:0]              free_q;
  logic [3:0]              free_d;
  logic [`N_UC-1:0]        retry_q;
  logic [`N_UC-1:0]        retry_d;

  logic [`N_SRC-1:0]       req     [`N_PRIO];
  logic [`N_PRIO-1:0]      cand_valid;
  logic [3:0]              cand_idx [`N_PRIO];
  logic [`N_PRIO-1:0]      accept;
  logic [`N_PRIO-1:0]      take;
  logic [3:0]              free_now;
  logic [3:0]              thr_of   [`N_PRIO];
  logic                    win;
  logic [1:0]              win_prio;
  logic                    do_retire;

  // split head packets into per-priority request vectors
  always_comb
  begin
    for (int p = 0; p < `N_PRIO; p++)
      for (int s = 0; s < `N_SRC; s++)
        req[p][s] = heads[s].valid && heads[s].prio == 2'(p);
  end

  generate
    for (genvar p = 0; p < `N_PRIO; p++)
    begin : g_wrr
      weighted_round_robin u_wrr (
        .clk        (clk),
        .nrst       (nrst),
        .ce         (ce),
        .uc_req     (req[p][`N_UC-1:0]),
        .mc_req     (req[p][`N_SRC-1]),
        .cfg        (wrr_cfg[p]),
        .take       (take[p]),
        .cand_valid (cand_valid[p]),
        .cand_idx   (cand_idx[p])
      );
    end
  endgenerate

  // watermark check and strict priority choice
  always_comb
  begin
    free_now  = `QUEUE_DEPTH - occ_q;
    thr_of[0] = thr_q.lowest_prio_threshold;
    thr_of[1] = thr_q.low_prio_threshold;
    thr_of[2] = thr_q.high_prio_threshold;
    thr_of[3] = `OCC_RST;
    for (int p = 0; p < `N_PRIO - 1; p++)
      accept[p] = free_now > thr_of[p];
    accept[`N_PRIO-1] = free_now != `OCC_RST;
    win      = 1'b0;
    win_prio = `PRIO_RST;
    // ascending scan: the highest eligible priority overwrites
    for (int p = 0; p < `N_PRIO; p++)
      if (cand_valid[p] && accept[p] && !gvalid_q)
      begin
        win      = 1'b1;
        win_prio = 2'(p);
      end
    take = '0;
    if (win)
      take[win_prio] = 1'b1;
  end

  // grant register, one decision per two cycles so the head can advance
  always_comb
  begin
    grant_d  = '0;
    gvalid_d = win;
    gprio_d  = gprio_q;
    if (win)
    begin
      grant_d[cand_idx[win_prio]] = 1'b1;
      gprio_d = win_prio;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      grant_q  <= '0;
      gvalid_q <= 1'b0;
      gprio_q  <= `PRIO_RST;
    end
    else if (ce)
    begin
      grant_q  <= grant_d;
      gvalid_q <= gvalid_d;
      gprio_q  <= gprio_d;
    end
  end

  // output queue occupancy and flow control
  always_comb
  begin
    do_retire = egress_retire && occ_q != `OCC_RST;
    occ_d     = occ_q;
    if (win && !do_retire)
      occ_d = occ_q + `OCC_ONE;
    else if (!win && do_retire)
      occ_d = occ_q - `OCC_ONE;
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      occ_q <= `OCC_RST;
    end
    else if (ce)
    begin
      occ_q <= occ_d;
    end
  end

  // flow control toward ingress, taken from the next occupancy
  always_comb
  begin
    free_d = `QUEUE_DEPTH - occ_d;
    full_d = occ_d == `QUEUE_DEPTH;
    for (int p = 0; p < `N_PRIO - 1; p++)
      stall_d[p] = !(free_d > thr_of[p]);
    stall_d[`N_PRIO-1] = full_d;
    for (int s = 0; s < `N_UC; s++)
      retry_d[s] = ingress_full[s] && heads[s].valid
                   && stall_d[heads[s].prio];
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      stall_q <= '0;
      full_q  <= 1'b0;
      free_q  <= `QUEUE_DEPTH;
      retry_q <= '0;
    end
    else if (ce)
    begin
      stall_q <= stall_d;
      full_q  <= full_d;
      free_q  <= free_d;
      retry_q <= retry_d;
    end
  end

  // threshold registers, loaded as one group
  always_comb
  begin
    thr_d = thr_q;
    if (thr_load)
      thr_d = thr_in;
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      thr_q.lowest_prio_threshold <= `THR0_RST;
      thr_q.low_prio_threshold    <= `THR1_RST;
      thr_q.high_prio_threshold   <= `THR2_RST;
    end
    else if (ce)
    begin
      thr_q <= thr_d;
    end
  end

  assign grant        = grant_q;
  assign grant_valid  = gvalid_q;
  assign grant_prio   = gprio_q;
  assign prio_stall   = stall_q;
  assign queue_full   = full_q;
  assign free_buffers = free_q;
  assign link_retry   = retry_q;
  assign thresholds   = thr_q;

endmodule
`default_nettype wire

// [egress_priority_wrr_arbiter_checker.sv]
// port checker for the egress priority arbiter
// assumes ce stays high while a grant is out
`timescale 1ns/1ns
`default_nettype none
module egress_priority_wrr_arbiter_checker
  import egress_arb_pkg::*;
(
  input wire logic        clk,
  input wire logic        nrst,
  input wire logic        egress_retire,
  input wire logic [7:0]  ingress_full,
  input wire logic [8:0]  grant,
  input wire logic        grant_valid,
  input wire logic [1:0]  grant_prio,
  input wire logic [3:0]  prio_stall,
  input wire logic        queue_full,
  input wire logic [3:0]  free_buffers,
  input wire logic [7:0]  link_retry,
  input wire thresholds_t thresholds
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  a_one_grant: assert property (grant_valid |-> $onehot(grant))
    else $error("grant not one-hot");
  a_grant_gap: assert property (grant_valid |=> !grant_valid)
    else $error("grants not spaced");
  a_idle_grant: assert property (!grant_valid |-> grant == 9'h000)
    else $error("grant without valid");
  a_free_track: assert property ($past(nrst) && !$past(egress_retire) |->
    free_buffers == $past(free_buffers) - {3'h0, grant_valid})
    else $error("free count off");
  a_full_flag: assert property (queue_full == (free_buffers == 4'h0))
    else $error("full flag off");
  a_top_stall: assert property (prio_stall[3] == queue_full)
    else $error("top stall off");
  a_mark_pass: assert property (grant_valid && grant_prio != 2'h3 |->
    $past(free_buffers) > 4'($past(thresholds) >> (4 * (2 - grant_prio))))
    else $error("grant below mark");
  a_top_pass: assert property (grant_valid && grant_prio == 2'h3 |-> $past(free_buffers) != 4'h0)
    else $error("top grant when full");
  a_retry_cause: assert property ((link_retry & ~$past(ingress_full)) == 8'h00)
    else $error("retry without full");
  a_reset_vals: assert property ($rose(nrst) |-> free_buffers == 4'h8 && thresholds == 12'h321)
    else $error("reset values off");
  c_top: cover property (grant_valid && grant_prio == 2'h3);
  c_full: cover property (queue_full);
  c_retry: cover property (link_retry != 8'h00);
endmodule
bind egress_priority_wrr_arbiter egress_priority_wrr_arbiter_checker chk (.clk, .nrst, .egress_retire,
  .ingress_full, .grant, .grant_valid, .grant_prio, .prio_stall, .queue_full, .free_buffers,
  .link_retry, .thresholds);
`default_nettype wire

// [ingress_source_model.sv]
// head-of-line packets of the ingress queues and broadcast buffer
// assumes the bench loads packets and names sources that refill
`timescale 1ns/1ns
`default_nettype none
module ingress_source_model
  import egress_arb_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic [8:0]  load,
  input  wire logic [1:0]  load_prio,
  input  wire logic [8:0]  refill,
  input  wire logic [8:0]  grant,
  input  wire logic        grant_valid,
  output var  head_t [8:0] heads
);
  head_t [8:0] held_q;
  head_t [8:0] held_d;
  logic  [8:0] taken;
  always_comb
  begin
    taken  = grant_valid ? (grant & ~refill) : 9'h000;
    held_d = held_q;
    heads  = held_q;
    for (int i = 0; i < 9; i++)
    begin
      if (load[i])
        held_d[i] = '{1'b1, load_prio};
      if (taken[i])
        held_d[i].valid = 1'b0;
      heads[i].valid = held_q[i].valid & ~taken[i];
      if (!heads[i].valid)
        heads[i].prio = ~held_q[i].prio;
    end
  end
  always_ff @(posedge clk)
  begin
    if (!nrst)
      held_q <= '0;
    else
      held_q <= held_d;
  end
endmodule
`default_nettype wire

// [egress_priority_wrr_arbiter_bench.sv]
// self-checking bench for the egress priority arbiter
// assumes the ingress source model and the bound checker
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) \
  begin err_total++; $display("[ERR] %s exp %0h got %0h", n, e, g); end end
module egress_priority_wrr_arbiter_bench
  import egress_arb_pkg::*;
;
  logic           clk           = 1'b0;
  logic           nrst          = 1'b0;
  logic           ce            = 1'b1;
  logic [8:0]     load          = 9'h000;
  logic [8:0]     refill        = 9'h000;
  logic [1:0]     load_prio     = 2'h0;
  logic [7:0]     ingress_full  = 8'h00;
  wrr_cfg_t [3:0] wrr_cfg       = '0;
  logic           thr_load      = 1'b0;
  thresholds_t    thr_in        = '0;
  logic           egress_retire = 1'b0;
  head_t [8:0]    heads;
  logic [8:0]     grant;
  logic           grant_valid;
  logic [1:0]     grant_prio;
  logic [3:0]     prio_stall;
  logic           queue_full;
  logic [3:0]     free_buffers;
  logic [7:0]     link_retry;
  thresholds_t    thresholds;
  logic [8:0]     g;
  logic [5:0]     pat;
  int             err_total     = 0;
  int             num_checks    = 0;
  always #2 clk = ~clk;
  ingress_source_model src (.clk, .nrst, .load, .load_prio, .refill, .grant, .grant_valid, .heads);
  egress_priority_wrr_arbiter dut (.clk, .nrst, .ce, .heads, .ingress_full, .wrr_cfg, .thr_load,
    .thr_in, .egress_retire, .grant, .grant_valid, .grant_prio, .prio_stall, .queue_full,
    .free_buffers, .link_retry, .thresholds);
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic ticks(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic do_reset();
    nrst = 1'b0;
    ticks(20);
    nrst = 1'b1;
  endtask
  task automatic put(input logic [8:0] m, input logic [1:0] p);
    load      = m;
    load_prio = p;
    ticks(1);
    load = 9'h000;
    ticks(1);
  endtask
  task automatic wait_grant(output logic [8:0] got);
    for (int i = 0; i < 40 && grant_valid !== 1'b1; i++)
      ticks(1);
    if (grant_valid !== 1'b1)
    begin
      err_total++;
      $display("[ERR] grant wait exp 1 got 0");
      test_done();
    end
    got = grant;
    ticks(1);
  endtask
  task automatic run_wrr(input logic [8:0] m, input logic fav, input logic [3:0] n, input logic [5:0] ep);
    do_reset();
    wrr_cfg[0]    = '{1'b1, fav, n};
    refill        = m;
    egress_retire = 1'b1;
    put(m, 2'h0);
    for (int k = 0; k < 6; k++)
    begin
      wait_grant(g);
      pat[k] = g[8];
    end
    `CHK("mc pattern", ep, pat)
    $display("test weighted done");
  endtask
  initial
  begin
    do_reset();
    `CHK("thr reset", 12'h321, thresholds)
    ce = 1'b0;
    put(9'h008, 2'h2);
    put(9'h100, 2'h3);
    `CHK("frozen", 4'h8, free_buffers)
    ce = 1'b1;
    wait_grant(g);
    `CHK("first grant", 9'h100, g)
    `CHK("first prio", 2'h3, grant_prio)
    wait_grant(g);
    `CHK("second grant", 9'h008, g)
    `CHK("second prio", 2'h2, grant_prio)
    `CHK("free after two", 4'h6, free_buffers)
    $display("test strict done");
    egress_retire = 1'b1;
    ce = 1'b0;
    put(9'h1ff, 2'h1);
    ce = 1'b1;
    for (int k = 0; k < 9; k++)
    begin
      wait_grant(g);
      `CHK("rr order", 9'h001 << k, g)
    end
    $display("test round robin done");
    run_wrr(9'h101, 1'b0, 4'h1, 6'b010101);
    run_wrr(9'h101, 1'b1, 4'h2, 6'b100100);
    run_wrr(9'h101, 1'b0, 4'h0, 6'b000000);
    run_wrr(9'h101, 1'b1, 4'h0, 6'b111111);
    run_wrr(9'h100, 1'b1, 4'h2, 6'b111111);
    run_wrr(9'h100, 1'b0, 4'h0, 6'b111111);
    do_reset();
    egress_retire = 1'b0;
    refill = 9'h002;
    put(9'h002, 2'h0);
    ticks(30);
    `CHK("free at mark", 4'h3, free_buffers)
    `CHK("stall low", 4'h1, prio_stall)
    ingress_full = 8'h02;
    ticks(3);
    `CHK("retry", 8'h02, link_retry)
    refill = 9'h022;
    put(9'h020, 2'h3);
    ticks(30);
    `CHK("full", 1'b1, queue_full)
    `CHK("stall full", 4'hf, prio_stall)
    thr_in = '{4'h5, 4'h4, 4'h2};
    thr_load = 1'b1;
    ticks(1);
    thr_load = 1'b0;
    `CHK("thr load", 12'h542, thresholds)
    $display("test watermark done");
    test_done();
  end
endmodule
`default_nettype wire
